// [hw/irqen_consts.svh]
// Purpose: Constants of the peripheral interrupt enable bank.
// Assumes: Included by bare name; definitions only.
// Notes: Offsets index byte registers on the plain register port.
`ifndef IRQEN_CONSTS_SVH
`define IRQEN_CONSTS_SVH

// Register offsets
`define ADDR_EN1 4'h0
`define ADDR_EN2 4'h1
`define ADDR_EN3 4'h2
`define ADDR_EN4 4'h3
`define ADDR_EN5 4'h4
`define ADDR_PRI1 4'h5
`define ADDR_PRI2 4'h6
`define ADDR_PRI3 4'h7
`define ADDR_PRI4 4'h8
`define ADDR_PRI5 4'h9
`define ADDR_PRI6 4'ha
`define ADDR_CTRL 4'hb
`define ADDR_STAT 4'hc
`define ADDR_MASK 4'hd
`define NUM_CTL_REGS 11

// Writable bits per register
`define WMASK_EN1 8'hff
`define WMASK_EN2 8'h8f
`define WMASK_EN3 8'h0e
`define WMASK_EN4 8'hf7
`define WMASK_EN5 8'hff
`define WMASK_EN5_M1 8'hfe
`define WMASK_PRI1 8'hff
`define WMASK_PRI2 8'h8f
`define WMASK_PRI3 8'h3e
`define WMASK_PRI4 8'hf7
`define WMASK_PRI5 8'hff
`define WMASK_PRI6 8'hff
`define WMASK_CTRL 8'hc3

// Reset values
`define RST_EN 8'h00
`define RST_PRI 8'hff
`define RST_CTRL 8'h00

// Control fields
`define CTRL_PRIO_EN_BIT 7
`define CTRL_GROUP_EN_BIT 6
`define CTRL_MODE_LSB 0

// Status bits
`define STAT_HIGH_BIT 0
`define STAT_LOW_BIT 1
`define STAT_WIDTH 2

`endif

// [hw/irqen_pkg.sv]
// Purpose: Types of the peripheral interrupt enable bank.
// Assumes: Constants live in irqen_consts.svh.
// Notes: None.
package irqen_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [3:0] addr_t;
	typedef logic [39:0] src_t;
	typedef enum logic [1:0] {
		CAN_MODE_LEGACY = 2'h0,
		CAN_MODE_ENHANCED = 2'h1,
		CAN_MODE_FIFO = 2'h2,
		CAN_MODE_RSVD = 2'h3
	} can_mode_e;
endpackage : irqen_pkg

// [hw/irq_route.sv]
// Purpose: Gates flags by enables and sorts requests by priority.
// Assumes: All inputs are on the system clock.
// Notes: Combinational; the caller registers the outputs.
`timescale 1ns/1ps
module irq_route (
	// Sources
	input wire irqen_pkg::src_t i_flags,
	input wire irqen_pkg::src_t i_enables,
	input wire irqen_pkg::src_t i_priority,
	// Control
	input wire logic i_prio_en,
	input wire logic i_group_en,
	// Requests
	output logic o_req_high,
	output logic o_req_low
);
	import irqen_pkg::*;
	src_t active;
	logic any_high;
	logic any_low;
	logic any_act;

	assign active = i_flags & i_enables;
	assign any_act = |active;
	assign any_high = |(active & i_priority);
	assign any_low = |(active & ~i_priority);
	// Single level: everything on the high line behind the group enable
	assign o_req_high = i_prio_en ? any_high : (i_group_en & any_act);
	assign o_req_low = i_prio_en & any_low;
endmodule : irq_route

// [hw/sticky_status.sv]
// Purpose: Sticky event status with mask and one level interrupt.
// Assumes: Clear by writing one; set wins over clear.
// Notes: None.
`timescale 1ns/1ps
module sticky_status #(
	parameter int W = 2
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Events and software access
	input wire logic [W-1:0] i_set,
	input wire logic i_clr_wr,
	input wire logic i_mask_wr,
	input wire logic [W-1:0] i_wdata,
	// State
	output logic [W-1:0] o_status,
	output logic [W-1:0] o_mask,
	output logic o_irq
);
	logic [W-1:0] status_ff;
	logic [W-1:0] mask_ff;
	logic [W-1:0] nxt_status;
	logic [W-1:0] clr_bits;

	assign clr_bits = i_clr_wr ? i_wdata : '0;
	assign nxt_status = (status_ff & ~clr_bits) | i_set;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status_ff <= '0;
			mask_ff <= '0;
		end else begin
			status_ff <= nxt_status;
			if (i_mask_wr) begin
				mask_ff <= i_wdata;
			end
		end
	end

	assign o_status = status_ff;
	assign o_mask = mask_ff;
	assign o_irq = |(status_ff & mask_ff);
endmodule : sticky_status

// [hw/periph_irq_enable_bank.sv]
// Purpose: Five peripheral interrupt enable registers, priority
//   registers and the request path to the core.
// Assumes: Flags come from logic on i_mclk; plain register port.
// Notes: Read data stands only in the cycle after the read strobe.
`timescale 1ns/1ps
`include "irqen_consts.svh"
module periph_irq_enable_bank (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Register port
	input wire irqen_pkg::addr_t i_addr,
	input wire irqen_pkg::byte_t i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output irqen_pkg::byte_t o_rdata,
	// Peripheral flags
	input wire irqen_pkg::byte_t i_flags_one,
	input wire irqen_pkg::byte_t i_flags_two,
	input wire irqen_pkg::byte_t i_flags_three,
	input wire irqen_pkg::byte_t i_flags_four,
	input wire irqen_pkg::byte_t i_flags_five,
	// Core requests
	output logic o_irq_high,
	output logic o_irq_low,
	output logic o_irq
);
	import irqen_pkg::*;

	localparam int NUM_CTL = `NUM_CTL_REGS;

	function automatic byte_t wr_mask(input addr_t idx, input can_mode_e m);
		unique case (idx)
			`ADDR_EN1: wr_mask = `WMASK_EN1;
			`ADDR_EN2: wr_mask = `WMASK_EN2;
			`ADDR_EN3: wr_mask = `WMASK_EN3;
			`ADDR_EN4: wr_mask = `WMASK_EN4;
			`ADDR_EN5: wr_mask = (m == CAN_MODE_ENHANCED) ? `WMASK_EN5_M1 : `WMASK_EN5;
			`ADDR_PRI1: wr_mask = `WMASK_PRI1;
			`ADDR_PRI2: wr_mask = `WMASK_PRI2;
			`ADDR_PRI3: wr_mask = `WMASK_PRI3;
			`ADDR_PRI4: wr_mask = `WMASK_PRI4;
			`ADDR_PRI5: wr_mask = `WMASK_PRI5;
			`ADDR_PRI6: wr_mask = `WMASK_PRI6;
			default: wr_mask = 8'h00;
		endcase
	endfunction : wr_mask

	function automatic byte_t rst_val(input int idx);
		rst_val = (idx < 5) ? `RST_EN : (`RST_PRI & wr_mask(addr_t'(idx), CAN_MODE_LEGACY));
	endfunction : rst_val

	function automatic byte_t merge(input byte_t old, input byte_t nw, input byte_t m);
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	// Enable and priority storage, indexed by offset
	byte_t ctl_ff [0:NUM_CTL-1];
	byte_t ctrl_ff;
	byte_t rdata_ff;
	logic high_ff;
	logic low_ff;

	can_mode_e mode;
	logic prio_en;
	logic group_en;
	logic bit0_live;
	logic ctl_hit;
	logic ctrl_wr;
	logic stat_wr;
	logic mask_wr;
	byte_t en5_view;
	byte_t ctl_view;
	byte_t rd_word;
	src_t flag_vec;
	src_t en_vec;
	src_t pri_vec;
	logic req_high;
	logic req_low;
	logic [`STAT_WIDTH-1:0] stat_set;
	logic [`STAT_WIDTH-1:0] status;
	logic [`STAT_WIDTH-1:0] smask;

	// Named enables
	logic parallel_port_rw_irq_en, converter_done_irq_en;
	logic serial1_rx_irq_en, serial1_tx_irq_en, sync_serial_irq_en;
	logic timer_one_gate_irq_en, timer_two_match_irq_en, timer_one_overflow_irq_en;
	logic osc_fail_irq_en, bus_collision_irq_en, voltage_detect_irq_en;
	logic timer_three_overflow_irq_en, timer_three_gate_irq_en;
	logic serial2_rx_irq_en, serial2_tx_irq_en, charge_time_unit_irq_en;
	logic capcomp_two_irq_en, enh_capcomp_one_irq_en;
	logic timer_four_overflow_irq_en, nvm_write_done_irq_en;
	logic comparator_two_irq_en, comparator_one_irq_en;
	logic capcomp_five_irq_en, capcomp_four_irq_en, capcomp_three_irq_en;
	logic can_invalid_msg_irq_en, can_wake_activity_irq_en, can_error_irq_en;
	logic can_txbuf_two_irq_en, can_txbuf_one_irq_en, can_txbuf_zero_irq_en;
	logic can_rxbuf_one_irq_en, can_rxbuf_zero_irq_en, can_fifo_full_irq_en;

	// Control decode
	assign mode = can_mode_e'(ctrl_ff[`CTRL_MODE_LSB +: 2]);
	assign prio_en = ctrl_ff[`CTRL_PRIO_EN_BIT];
	assign group_en = ctrl_ff[`CTRL_GROUP_EN_BIT];
	assign bit0_live = (mode == CAN_MODE_LEGACY) || (mode == CAN_MODE_FIFO);

	// Address decode
	assign ctl_hit = i_addr < addr_t'(NUM_CTL);
	assign ctrl_wr = i_wr && (i_addr == `ADDR_CTRL);
	assign stat_wr = i_wr && (i_addr == `ADDR_STAT);
	assign mask_wr = i_wr && (i_addr == `ADDR_MASK);

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int k = 0; k < NUM_CTL; k++) begin
				ctl_ff[k] <= rst_val(k);
			end
		end else if (i_wr && ctl_hit) begin
			ctl_ff[i_addr] <= merge(ctl_ff[i_addr], i_wdata, wr_mask(i_addr, mode));
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_ff <= `RST_CTRL;
		end else if (ctrl_wr) begin
			ctrl_ff <= merge(ctrl_ff, i_wdata, `WMASK_CTRL);
		end
	end

	// Field map of the enable registers
	assign {parallel_port_rw_irq_en, converter_done_irq_en, serial1_rx_irq_en,
		serial1_tx_irq_en, sync_serial_irq_en, timer_one_gate_irq_en,
		timer_two_match_irq_en, timer_one_overflow_irq_en} = ctl_ff[0];
	assign osc_fail_irq_en = ctl_ff[1][7];
	assign {bus_collision_irq_en, voltage_detect_irq_en, timer_three_overflow_irq_en,
		timer_three_gate_irq_en} = ctl_ff[1][3:0];
	assign {serial2_rx_irq_en, serial2_tx_irq_en, charge_time_unit_irq_en,
		capcomp_two_irq_en, enh_capcomp_one_irq_en} = ctl_ff[2][5:1];
	assign {timer_four_overflow_irq_en, nvm_write_done_irq_en, comparator_two_irq_en,
		comparator_one_irq_en} = ctl_ff[3][7:4];
	assign {capcomp_five_irq_en, capcomp_four_irq_en,
		capcomp_three_irq_en} = ctl_ff[3][2:0];
	// Error enable gates the combined CAN error flag
	assign {can_invalid_msg_irq_en, can_wake_activity_irq_en, can_error_irq_en,
		can_txbuf_two_irq_en, can_txbuf_one_irq_en, can_txbuf_zero_irq_en,
		can_rxbuf_one_irq_en} = ctl_ff[4][7:1];
	assign can_rxbuf_zero_irq_en = ctl_ff[4][0] & (mode == CAN_MODE_LEGACY);
	assign can_fifo_full_irq_en = ctl_ff[4][0] & (mode == CAN_MODE_FIFO);

	// Request path vectors, first register in the low byte
	assign flag_vec = {i_flags_five, i_flags_four, i_flags_three, i_flags_two, i_flags_one};
	assign en_vec = {
		can_invalid_msg_irq_en, can_wake_activity_irq_en, can_error_irq_en,
		can_txbuf_two_irq_en, can_txbuf_one_irq_en, can_txbuf_zero_irq_en,
		can_rxbuf_one_irq_en, can_rxbuf_zero_irq_en | can_fifo_full_irq_en,
		timer_four_overflow_irq_en, nvm_write_done_irq_en, comparator_two_irq_en,
		comparator_one_irq_en, 1'b0, capcomp_five_irq_en, capcomp_four_irq_en,
		capcomp_three_irq_en,
		2'h0, serial2_rx_irq_en, serial2_tx_irq_en, charge_time_unit_irq_en,
		capcomp_two_irq_en, enh_capcomp_one_irq_en, 1'b0,
		osc_fail_irq_en, 3'h0, bus_collision_irq_en, voltage_detect_irq_en,
		timer_three_overflow_irq_en, timer_three_gate_irq_en,
		parallel_port_rw_irq_en, converter_done_irq_en, serial1_rx_irq_en,
		serial1_tx_irq_en, sync_serial_irq_en, timer_one_gate_irq_en,
		timer_two_match_irq_en, timer_one_overflow_irq_en};
	assign pri_vec = {ctl_ff[9], ctl_ff[8], ctl_ff[7], ctl_ff[6], ctl_ff[5]};

	irq_route u_route (
		.i_flags(flag_vec),
		.i_enables(en_vec),
		.i_priority(pri_vec),
		.i_prio_en(prio_en),
		.i_group_en(group_en),
		.o_req_high(req_high),
		.o_req_low(req_low)
	);

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			high_ff <= 1'b0;
			low_ff <= 1'b0;
		end else begin
			high_ff <= req_high;
			low_ff <= req_low;
		end
	end

	// Rising requests are the status events
	assign stat_set[`STAT_HIGH_BIT] = req_high & ~high_ff;
	assign stat_set[`STAT_LOW_BIT] = req_low & ~low_ff;

	sticky_status #(
		.W(`STAT_WIDTH)
	) u_status (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_set(stat_set),
		.i_clr_wr(stat_wr),
		.i_mask_wr(mask_wr),
		.i_wdata(i_wdata[`STAT_WIDTH-1:0]),
		.o_status(status),
		.o_mask(smask),
		.o_irq(o_irq)
	);

	// Read selection
	assign en5_view = {ctl_ff[4][7:1], ctl_ff[4][0] & bit0_live};
	assign ctl_view = (i_addr == `ADDR_EN5) ? en5_view : ctl_ff[i_addr];
	assign rd_word = ctl_hit ? ctl_view :
		(i_addr == `ADDR_CTRL) ? ctrl_ff :
		(i_addr == `ADDR_STAT) ? {6'h00, status} :
		(i_addr == `ADDR_MASK) ? {6'h00, smask} : 8'h00;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= i_rd ? rd_word : 8'h00;
		end
	end

	assign o_rdata = rdata_ff;
	assign o_irq_high = high_ff;
	assign o_irq_low = low_ff;

	// Checks
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_rd_at(addr_t a);
		i_rd && (i_addr == a);
	endsequence

	sequence s_wr_at(addr_t a);
		i_wr && (i_addr == a);
	endsequence

	a_enable_write_lands: assert property (
		s_wr_at(`ADDR_EN1) |=> (ctl_ff[0] == $past(i_wdata))
	) else $error("enable write not stored");

	a_reset_all_clear: assert property (
		$rose(i_rst_n) |-> (ctl_ff[0] == 8'h00) && (ctl_ff[1] == 8'h00)
			&& (ctl_ff[2] == 8'h00) && (ctl_ff[3] == 8'h00) && (ctl_ff[4] == 8'h00)
	) else $error("enable not clear after reset");

	a_unimpl_reads_zero: assert property (
		s_rd_at(`ADDR_EN2) or s_rd_at(`ADDR_EN4)
			|=> (($past(i_addr) == `ADDR_EN2) ? (o_rdata[6:4] == 3'h0)
			: (o_rdata[3] == 1'b0))
	) else $error("unimplemented bit read non-zero");

	a_serial_two_ro: assert property (
		s_rd_at(`ADDR_EN3)
			|=> o_rdata[5:4] == 2'h0 && o_rdata[7:6] == 2'h0 && o_rdata[0] == 1'b0
	) else $error("read-only enable bits changed");

	a_mode_one_hides: assert property (
		s_rd_at(`ADDR_EN5) and (mode == CAN_MODE_ENHANCED) |=> o_rdata[0] == 1'b0
	) else $error("bit zero visible in mode one");

	a_group_gate: assert property (
		!prio_en && !group_en |=> !o_irq_high && !o_irq_low
	) else $error("request passed without group enable");

	a_single_level: assert property (
		!prio_en [*2] |-> !o_irq_low
	) else $error("low request without priority levels");

	a_high_route: assert property (
		prio_en && |(flag_vec & en_vec & pri_vec) |=> o_irq_high
	) else $error("high priority source not routed high");

	a_low_route: assert property (
		prio_en && |(flag_vec & en_vec & ~pri_vec) |=> o_irq_low
	) else $error("low priority source not routed low");

	a_any_request: assert property (
		!prio_en && group_en && |(flag_vec & en_vec) |=> o_irq_high
	) else $error("enabled flag gave no request");

	a_blocked_source: assert property (
		(en_vec == '0) |=> !o_irq_high && !o_irq_low
	) else $error("request with all enables off");

	a_prio_unimpl: assert property (
		(ctl_ff[6] & ~`WMASK_PRI2) == 8'h00 && (ctl_ff[8] & ~`WMASK_PRI4) == 8'h00
	) else $error("priority unimplemented bit set");

	a_read_one_cycle: assert property (
		!i_rd |=> o_rdata == 8'h00
	) else $error("read data outside its cycle");

	a_status_set_wins: assert property (
		stat_set[`STAT_HIGH_BIT] && stat_wr |=> status[`STAT_HIGH_BIT]
	) else $error("event lost under clear");

	sequence s_rise(b);
		!b ##1 b;
	endsequence

	a_unimpl_stored_zero: assert property (
		(ctl_ff[1] & ~`WMASK_EN2) == 8'h00 && (ctl_ff[2] & ~`WMASK_EN3) == 8'h00
			&& (ctl_ff[3] & ~`WMASK_EN4) == 8'h00
	) else $error("unimplemented enable bit stored");

	a_first_reads_back: assert property (
		s_rd_at(`ADDR_EN1) |=> o_rdata == $past(ctl_ff[0])
	) else $error("first enable register read wrong");

	a_prio_reads_back: assert property (
		s_rd_at(`ADDR_PRI1) |=> o_rdata == $past(ctl_ff[5])
	) else $error("first priority register read wrong");

	a_mode_one_keeps: assert property (
		s_wr_at(`ADDR_EN5) and (mode == CAN_MODE_ENHANCED)
			|=> ctl_ff[4][0] == $past(ctl_ff[4][0])
	) else $error("bit zero written in mode one");

	a_fifo_full_seen: assert property (
		s_rd_at(`ADDR_EN5) and (mode == CAN_MODE_FIFO)
			|=> o_rdata[0] == $past(ctl_ff[4][0])
	) else $error("bit zero hidden in fifo mode");

	a_error_enable: assert property (
		prio_en && i_flags_five[5] && ctl_ff[4][5] |=> o_irq_high || o_irq_low
	) else $error("CAN error source not routed");

	a_prio_skips_group: assert property (
		prio_en && !group_en && |(flag_vec & en_vec) |=> o_irq_high || o_irq_low
	) else $error("priority request held by group enable");

	a_high_edge_status: assert property (
		s_rise(o_irq_high) |-> status[`STAT_HIGH_BIT]
	) else $error("high request edge left no status");

	a_low_edge_status: assert property (
		s_rise(o_irq_low) |-> status[`STAT_LOW_BIT]
	) else $error("low request edge left no status");
endmodule : periph_irq_enable_bank

// [tb/flag_sources.sv]
// Purpose: Peripheral flag sources facing the enable bank.
// Assumes: The bench loads one flag byte per cycle.
// Notes: Flags are levels and hold until reloaded.
`timescale 1ns/1ps
module flag_sources (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Load port
	input wire logic i_load,
	input wire logic [2:0] i_idx,
	input wire irqen_pkg::byte_t i_val,
	// Flag levels
	output irqen_pkg::byte_t o_flags_one,
	output irqen_pkg::byte_t o_flags_two,
	output irqen_pkg::byte_t o_flags_three,
	output irqen_pkg::byte_t o_flags_four,
	output irqen_pkg::byte_t o_flags_five
);
	import irqen_pkg::*;
	byte_t flags_ff [5];
	// Indexes five to seven load nothing
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flags_ff <= '{default: 8'h00};
		end else if (i_load && (i_idx < 3'h5)) begin
			flags_ff[i_idx] <= i_val;
		end
	end
	assign o_flags_one = flags_ff[0];
	assign o_flags_two = flags_ff[1];
	assign o_flags_three = flags_ff[2];
	assign o_flags_four = flags_ff[3];
	assign o_flags_five = flags_ff[4];
endmodule : flag_sources

// [tb/tb_periph_irq_enable_bank.sv]
// Purpose: Self-checking bench of the interrupt enable bank.
// Assumes: Model mirrors registers, requests and status each edge.
// Notes: All outputs are compared at every falling edge.
`timescale 1ns/1ps
`include "irqen_consts.svh"
module tb_periph_irq_enable_bank;
	import irqen_pkg::*;
	localparam int WATCH_CYCLES = 20000;
	logic i_mclk;
	logic i_rst_n;
	addr_t i_addr;
	byte_t i_wdata;
	logic i_wr;
	logic i_rd;
	byte_t o_rdata;
	logic o_irq_high;
	logic o_irq_low;
	logic o_irq;
	byte_t fl [5];
	logic ld;
	logic [2:0] ld_idx;
	byte_t ld_val;
	logic [31:0] lfsr;
	int err_count;
	int n_tests;
	byte_t m_en [5];
	byte_t m_pri [6];
	byte_t m_ctrl;
	byte_t m_rdata;
	logic [1:0] m_stat;
	logic [1:0] m_mask;
	logic m_high;
	logic m_low;
	byte_t wm_en [5] = '{`WMASK_EN1, `WMASK_EN2, `WMASK_EN3, `WMASK_EN4, `WMASK_EN5};
	byte_t wm_pri [6] = '{`WMASK_PRI1, `WMASK_PRI2, `WMASK_PRI3, `WMASK_PRI4,
		`WMASK_PRI5, `WMASK_PRI6};

	periph_irq_enable_bank DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_flags_one(fl[0]), .i_flags_two(fl[1]), .i_flags_three(fl[2]),
		.i_flags_four(fl[3]), .i_flags_five(fl[4]), .o_irq_high(o_irq_high),
		.o_irq_low(o_irq_low), .o_irq(o_irq));
	flag_sources sources (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_load(ld), .i_idx(ld_idx),
		.i_val(ld_val), .o_flags_one(fl[0]), .o_flags_two(fl[1]), .o_flags_three(fl[2]),
		.o_flags_four(fl[3]), .o_flags_five(fl[4]));

	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	// Fifth register bit zero hidden in odd modes
	function automatic byte_t eff_en(int k);
		return (k == 4 && m_ctrl[`CTRL_MODE_LSB]) ? (m_en[4] & 8'hfe) : m_en[k];
	endfunction : eff_en

	function automatic byte_t read_val(addr_t a);
		if (a < 4'h5) return eff_en(a);
		if (a < 4'hb) return m_pri[a - 4'h5];
		if (a == `ADDR_CTRL) return m_ctrl;
		if (a == `ADDR_STAT) return {6'h00, m_stat};
		if (a == `ADDR_MASK) return {6'h00, m_mask};
		return 8'h00;
	endfunction : read_val

	always @(posedge i_mclk or negedge i_rst_n) begin : model
		logic any_h;
		logic any_l;
		byte_t g;
		logic [1:0] set;
		logic [1:0] nstat;
		if (!i_rst_n) begin
			m_en <= '{default: `RST_EN};
			m_pri <= wm_pri;
			m_ctrl <= `RST_CTRL;
			m_stat <= 2'h0;
			m_mask <= 2'h0;
			m_high <= 1'b0;
			m_low <= 1'b0;
			m_rdata <= 8'h00;
		end else begin
			any_h = 1'b0;
			any_l = 1'b0;
			for (int k = 0; k < 5; k++) begin
				g = fl[k] & eff_en(k);
				any_h = any_h | (|(g & m_pri[k]));
				any_l = any_l | (|(g & ~m_pri[k]));
			end
			if (!m_ctrl[`CTRL_PRIO_EN_BIT]) begin
				any_h = m_ctrl[`CTRL_GROUP_EN_BIT] & (any_h | any_l);
				any_l = 1'b0;
			end
			set = {any_l & ~m_low, any_h & ~m_high};
			nstat = m_stat | set;
			m_high <= any_h;
			m_low <= any_l;
			m_rdata <= i_rd ? read_val(i_addr) : 8'h00;
			if (i_wr) begin
				if (i_addr == `ADDR_EN5 && m_ctrl[`CTRL_MODE_LSB +: 2] == 2'h1) begin
					m_en[4] <= {i_wdata[7:1], m_en[4][0]};
				end else if (i_addr < 4'h5) begin
					m_en[i_addr] <= i_wdata & wm_en[i_addr];
				end else if (i_addr < 4'hb) begin
					m_pri[i_addr - 4'h5] <= i_wdata & wm_pri[i_addr - 4'h5];
				end else if (i_addr == `ADDR_CTRL) begin
					m_ctrl <= i_wdata & `WMASK_CTRL;
				end else if (i_addr == `ADDR_STAT) begin
					nstat = (m_stat & ~i_wdata[1:0]) | set;
				end else if (i_addr == `ADDR_MASK) begin
					m_mask <= i_wdata[1:0];
				end
			end
			m_stat <= nstat;
		end
	end

	task automatic check(byte_t seen, byte_t exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	always @(negedge i_mclk) begin
		check(o_rdata, m_rdata);
		check({7'h00, o_irq_high}, {7'h00, m_high});
		check({7'h00, o_irq_low}, {7'h00, m_low});
		check({7'h00, o_irq}, {7'h00, |(m_stat & m_mask)});
	end

	// One bus and flag cycle, then the next rising edge
	task automatic step(logic wr, logic rd, addr_t a, byte_t d, logic l, logic [2:0] li,
		byte_t lv);
		i_wr <= wr;
		i_rd <= rd;
		i_addr <= a;
		i_wdata <= d;
		ld <= l;
		ld_idx <= li;
		ld_val <= lv;
		@(posedge i_mclk);
	endtask : step

	task automatic read_all();
		for (int a = 0; a < 16; a++) begin
			step(1'b0, 1'b1, a[3:0], 8'h00, 1'b0, 3'h0, 8'h00);
		end
		step(1'b0, 1'b0, 4'h0, 8'h00, 1'b0, 3'h0, 8'h00);
	endtask : read_all

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end

	initial begin
		repeat (WATCH_CYCLES) @(posedge i_mclk);
		err_count++;
		tally_and_finish();
	end

	initial begin
		logic [31:0] r;
		i_rst_n = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		ld = 1'b0;
		ld_idx = 3'h0;
		ld_val = 8'h00;
		err_count = 0;
		n_tests = 0;
		lfsr = 32'h3bd9;
		repeat (20) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		@(posedge i_mclk);
		read_all();
		for (int a = 0; a < 16; a++) begin
			step(1'b1, 1'b0, a[3:0], 8'hff, 1'b0, 3'h0, 8'h00);
		end
		read_all();
		// Fifth register bit zero across the modes
		step(1'b0, 1'b0, 4'h0, 8'h00, 1'b1, 3'h4, 8'h01);
		for (int m = 0; m < 5; m++) begin
			step(1'b1, 1'b0, `ADDR_CTRL, byte_t'(8'h40 | (m % 4)), 1'b0, 3'h0, 8'h00);
			step(1'b0, 1'b1, `ADDR_EN5, 8'h00, 1'b0, 3'h0, 8'h00);
			step(1'b1, 1'b0, `ADDR_EN5, (m == 0) ? 8'h01 : 8'h00, 1'b0, 3'h0, 8'h00);
			repeat (3) step(1'b0, 1'b0, 4'h0, 8'h00, 1'b0, 3'h0, 8'h00);
		end
		// Status raise, mask, clear with high then low priority
		step(1'b1, 1'b0, `ADDR_CTRL, 8'hc0, 1'b1, 3'h4, 8'h00);
		step(1'b1, 1'b0, `ADDR_STAT, 8'h03, 1'b0, 3'h0, 8'h00);
		step(1'b1, 1'b0, `ADDR_PRI1, 8'h01, 1'b1, 3'h0, 8'h01);
		step(1'b1, 1'b0, `ADDR_MASK, 8'h03, 1'b0, 3'h0, 8'h00);
		step(1'b0, 1'b1, `ADDR_STAT, 8'h00, 1'b0, 3'h0, 8'h00);
		step(1'b1, 1'b0, `ADDR_STAT, 8'h03, 1'b0, 3'h0, 8'h00);
		step(1'b0, 1'b1, `ADDR_STAT, 8'h00, 1'b0, 3'h0, 8'h00);
		step(1'b1, 1'b0, `ADDR_PRI1, 8'h00, 1'b0, 3'h0, 8'h00);
		repeat (2) step(1'b0, 1'b1, `ADDR_STAT, 8'h00, 1'b0, 3'h0, 8'h00);
		step(1'b1, 1'b0, `ADDR_MASK, 8'h01, 1'b0, 3'h0, 8'h00);
		step(1'b1, 1'b0, `ADDR_STAT, 8'h02, 1'b1, 3'h0, 8'h00);
		// Clear in the very cycle of a new event
		step(1'b1, 1'b0, `ADDR_PRI1, 8'h01, 1'b0, 3'h0, 8'h00);
		step(1'b0, 1'b0, 4'h0, 8'h00, 1'b1, 3'h0, 8'h01);
		step(1'b1, 1'b0, `ADDR_STAT, 8'h01, 1'b0, 3'h0, 8'h00);
		step(1'b0, 1'b1, `ADDR_STAT, 8'h00, 1'b0, 3'h0, 8'h00);
		// Random traffic on registers and flags
		for (int i = 0; i < 3000; i++) begin
			lfsr = lfsr_next(lfsr);
			r = lfsr;
			step(r[1:0] == 2'h0, r[1:0] == 2'h1, r[5:2], r[13:6], r[14], r[17:15],
				r[25:18] & r[31:24]);
		end
		// Second reset in mid-run
		step(1'b0, 1'b0, 4'h0, 8'h00, 1'b0, 3'h0, 8'h00);
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		@(posedge i_mclk);
		read_all();
		tally_and_finish();
	end
endmodule : tb_periph_irq_enable_bank
